// file: buck_boost_mode_control.sv
// Modulation and mode control for the step-down and step-up regulators.
// Assumes APB master on pclk; analog comparators and wake_input are
// asynchronous and are synchronised here.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Step-up peak overcurrent lowers its duty cycle.
// - Normal mode runs step-down in fixed-frequency PWM.
// - Entering stop mode switches step-down to PFM automatically.
// - Enabled step-up in stop mode uses PWM only.
// - Stop-mode overload upshifts to PWM, raises event, sets upshift flag.
// - Upshift threshold typically 110 mA, limits 80 and 150 mA.
// - Only a stop command returns to PFM; host sends it after load drops.
// - Auto upshift inactive for lag: 1 ms when bit set, else 100 us.
// - PWM to PFM change on stop entry or stop command waits the lag time; wake-pin change does not.
// - Auto-upshift enable bit 0 disables current-triggered upshift.
// - Wake-pin select 1 lets wake input choose stop-mode modulation.
// - Wake low selects PFM, high selects PWM; source drives clean level.
// - No wake filter time while wake input steers modulation.
// - Wake-pin select 0 gives PFM in stop mode unless auto-upshifted.
// - Normal command from stop switches step-down to PWM.
// - After normal command, load above stop maximum is allowed.
// - Running step-up continues unchanged through stop to normal.
// - Sleep and fail-safe switch both converters off.
// - Wake in sleep or fail-safe goes to restart, then normal.
// - Restart ramps step-down; step-up resumes per prior configuration.
// - Reset output released once step-down passes reset threshold.
// - Host enables step-up and picks its level via control bits.
// - Step-up on below threshold, off above hysteresis; sets active flag.
// - Active flag clears only while sensed output above threshold.
module buck_boost_mode_control
    import smps_mode_pkg::*;
(
    // Clock and reset
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    // APB slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Pins and analog comparators (asynchronous)
    input  wire logic                     wake_input,
    input  wire smps_mode_pkg::analog_in_t analog_in,
    // Regulator controls
    output smps_mode_pkg::reg_out_t        reg_out,
    output smps_mode_pkg::sbc_mode_t       mode_state,
    output logic                          step_up_level
);
    import smps_mode_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        analog_in_t  an_s1;
        analog_in_t  an_s2;
        logic        wk_s1;
        logic        wk_s2;
        sbc_mode_t   mode;
        logic [4:0]  hardware_control_register;
        logic        upshift_flag;
        logic        step_up_active_flag;
        logic        upshifted;
        logic        pwm_hold;       // PWM held during lag to PFM
        logic [LAG_W-1:0] lag_cnt;
        logic        lag_done;
        logic        step_up_on;
        logic [4:0]  saved_hw;       // Normal-mode config for restart
        reg_out_t    out;
        sbc_mode_t   mode_q;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
    } state_t;

    state_t cur;
    state_t nxt;

    localparam logic [LAG_W-1:0] LAG_LONG  = LAG_W'(LAG_LONG_CYC - 1);
    localparam logic [LAG_W-1:0] LAG_SHORT = LAG_W'(LAG_SHORT_CYC - 1);

    // Address decode, used only for the pslverr response
    function automatic logic addr_known(input logic [7:0] a);
        return a == MODE_CTRL_ADDR || a == HW_CONTROL_ADDR ||
               a == WAKE_STAT1_ADDR || a == SMPS_STATE_ADDR;
    endfunction : addr_known

    logic       wr_acc;
    logic       rd_acc;
    logic       cmd_stop;
    logic       cmd_normal;
    logic       cmd_sleep;
    logic       auto_req;
    logic       wake_pwm;
    logic       pwm_req;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt = cur;
        // Two-stage synchronisers; only stage two is read below
        nxt.an_s1 = analog_in;
        nxt.an_s2 = cur.an_s1;
        nxt.wk_s1 = wake_input;
        nxt.wk_s2 = cur.wk_s1;

        // APB: zero-wait, pready high in the access cycle
        // Write lands at the access edge where pready is sampled high
        wr_acc = psel && penable && pwrite && cur.ready;
        rd_acc = psel && !penable && !pwrite;
        nxt.ready  = psel && !penable;
        nxt.slverr = psel && !penable && !addr_known(paddr);
        cmd_stop   = wr_acc && paddr == MODE_CTRL_ADDR
                     && pwdata[1:0] == CMD_STOP;
        cmd_normal = wr_acc && paddr == MODE_CTRL_ADDR
                     && pwdata[1:0] == CMD_NORMAL;
        cmd_sleep  = wr_acc && paddr == MODE_CTRL_ADDR
                     && pwdata[1:0] == CMD_SLEEP;

        if (wr_acc && paddr == HW_CONTROL_ADDR) begin
            nxt.hardware_control_register = pwdata[4:0];
        end

        // Mode sequencing
        nxt.out.upshift_event = 1'b0;
        unique case (cur.mode)
            MODE_NORMAL: begin
                nxt.saved_hw = cur.hardware_control_register;
                if (cmd_stop) begin
                    nxt.mode     = MODE_STOP;
                    nxt.pwm_hold = 1'b1;
                    nxt.lag_cnt  = cur.hardware_control_register[HW_LAG_SELECT]
                                   ? LAG_LONG : LAG_SHORT;
                    nxt.lag_done = 1'b0;
                    nxt.upshifted = 1'b0;
                end else if (cmd_sleep) begin
                    nxt.mode = MODE_SLEEP;
                end
            end
            MODE_STOP: begin
                if (cur.lag_cnt != '0) begin
                    nxt.lag_cnt = cur.lag_cnt - 1'b1;
                end else begin
                    nxt.lag_done = 1'b1;
                    nxt.pwm_hold = 1'b0;
                end
                if (cmd_normal) begin
                    nxt.mode = MODE_NORMAL;
                end else if (cmd_sleep) begin
                    nxt.mode = MODE_SLEEP;
                end else if (cmd_stop && cur.upshifted) begin
                    // Back to PFM only through the lag again
                    nxt.upshifted = 1'b0;
                    nxt.pwm_hold  = 1'b1;
                    nxt.lag_done  = 1'b0;
                    nxt.lag_cnt   = cur.hardware_control_register[HW_LAG_SELECT]
                                    ? LAG_LONG : LAG_SHORT;
                end else if (auto_req && !cur.upshifted) begin
                    nxt.upshifted = 1'b1;
                    nxt.out.upshift_event = 1'b1;
                end
            end
            MODE_SLEEP, MODE_FAILSAFE: begin
                if (cur.an_s2.wake_event) begin
                    nxt.mode = MODE_RESTART;
                end
            end
            MODE_RESTART: begin
                if (cur.out.reset_output_n) begin
                    nxt.mode = MODE_NORMAL;
                    nxt.hardware_control_register = cur.saved_hw;
                end
            end
            default: nxt.mode = MODE_FAILSAFE;
        endcase
        if (cur.an_s2.fail_safe_req && cur.mode != MODE_RESTART) begin
            nxt.mode = MODE_FAILSAFE;
        end

        // Upshift flag: set wins over software clear
        if (wr_acc && paddr == WAKE_STAT1_ADDR && pwdata[WS_UPSHIFT]) begin
            nxt.upshift_flag = 1'b0;
        end
        if (nxt.out.upshift_event) begin
            nxt.upshift_flag = 1'b1;
        end

        // Step-up hysteresis control
        if (!cur.hardware_control_register[HW_STEP_UP_EN]) begin
            nxt.step_up_on = 1'b0;
        end else if (cur.an_s2.step_up_below_th) begin
            nxt.step_up_on = 1'b1;
        end else if (cur.an_s2.step_up_above_hys) begin
            nxt.step_up_on = 1'b0;
        end
        if (wr_acc && paddr == WAKE_STAT1_ADDR && pwdata[WS_STEP_UP_ACT]
            && !cur.an_s2.step_up_below_th) begin
            nxt.step_up_active_flag = 1'b0;
        end
        if (cur.step_up_on) begin
            nxt.step_up_active_flag = 1'b1;
        end

        // Outputs
        nxt.out.step_down_en  = cur.mode != MODE_SLEEP
                                && cur.mode != MODE_FAILSAFE;
        nxt.out.step_down_pwm = pwm_req && nxt.out.step_down_en;
        nxt.out.step_up_en    = cur.step_up_on && nxt.out.step_down_en;
        nxt.out.duty_reduce   = cur.an_s2.step_up_overcurrent
                                && cur.step_up_on;
        nxt.out.reset_output_n = (cur.mode == MODE_RESTART)
                                 ? cur.an_s2.step_down_above_rst
                                 : nxt.out.step_down_en;
        nxt.mode_q = cur.mode;

        // Read mux
        nxt.rdata = 32'h0000_0000;
        if (rd_acc) begin
            unique case (paddr)
                MODE_CTRL_ADDR:  nxt.rdata[2:0] = cur.mode;
                HW_CONTROL_ADDR: nxt.rdata[4:0] = cur.hardware_control_register;
                WAKE_STAT1_ADDR: nxt.rdata[1:0] = {cur.step_up_active_flag,
                                                   cur.upshift_flag};
                SMPS_STATE_ADDR: nxt.rdata[3:0] = {cur.upshifted,
                                                   cur.out.step_up_en,
                                                   cur.out.step_down_pwm,
                                                   cur.lag_done};
                default:         nxt.rdata = 32'h0000_0000;
            endcase
        end else if (!psel) begin
            nxt.rdata = 32'h0000_0000;
        end else begin
            nxt.rdata = cur.rdata;
        end
    end

    // ------------------------------------------------------------
    // Modulation arbiter
    // ------------------------------------------------------------
    // Auto upshift only after lag, when enabled and pin control off
    always_comb begin
        auto_req = cur.mode == MODE_STOP && cur.lag_done
                   && cur.hardware_control_register[HW_AUTO_UPSHIFT]
                   && !cur.hardware_control_register[HW_WAKE_PIN_MOD]
                   && cur.an_s2.step_down_high_load;
        // Unfiltered pin level, synchroniser only
        wake_pwm = cur.wk_s2;
        unique case (cur.mode)
            MODE_STOP: begin
                if (cur.pwm_hold) begin
                    pwm_req = 1'b1;
                end else if (cur.hardware_control_register[HW_WAKE_PIN_MOD]) begin
                    pwm_req = wake_pwm;
                end else begin
                    pwm_req = cur.upshifted;
                end
            end
            MODE_NORMAL, MODE_RESTART: pwm_req = 1'b1;
            default:                   pwm_req = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur         <= '0;
            cur.mode    <= MODE_RESTART;   // Power-up ramps like restart
            cur.mode_q  <= MODE_RESTART;
            cur.hardware_control_register <= HW_CONTROL_RESET;
            cur.saved_hw <= HW_CONTROL_RESET;
        end else begin
            cur <= nxt;
        end
    end

    assign prdata        = cur.rdata;
    assign pready        = cur.ready;
    assign pslverr       = cur.slverr;
    assign reg_out       = cur.out;
    assign mode_state    = cur.mode_q;
    assign step_up_level = cur.hardware_control_register[HW_STEP_UP_LEVEL];

endmodule : buck_boost_mode_control
`default_nettype wire

// file: buck_boost_mode_control_sva.sv
// Checker for the buck/boost modulation control block.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module buck_boost_mode_control_sva
    import smps_mode_pkg::*;
(
    // Clock and reset
    input wire logic                     pclk,
    input wire logic                     presetn,
    // APB slave
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [7:0]               paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    // Pins and regulator controls
    input wire logic                     wake_input,
    input wire smps_mode_pkg::analog_in_t analog_in,
    input wire smps_mode_pkg::reg_out_t   reg_out,
    input wire smps_mode_pkg::sbc_mode_t  mode_state,
    input wire logic                     step_up_level
);
    logic [4:0] hw;

    // Mirror of the control-bit writes, taken at the same edge as the design; the restart restore of saved_hw is not copied
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hw <= HW_CONTROL_RESET;
        end else if (psel && penable && pwrite && pready && !pslverr
                     && paddr == HW_CONTROL_ADDR) begin
            hw <= pwdata[4:0];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("no answer in first access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held over two cycles");
    duty_follow_a: assert property (
        (analog_in.step_up_overcurrent && reg_out.step_up_en)[*5]
        |-> reg_out.duty_reduce) else $error("overcurrent ignored");
    normal_pwm_a: assert property (
        mode_state == MODE_NORMAL && $past(mode_state) == MODE_NORMAL
        |-> reg_out.step_down_pwm) else $error("normal mode not pwm");
    sleep_off_a: assert property (
        mode_state inside {MODE_SLEEP, MODE_FAILSAFE}
        && $stable(mode_state)
        |-> !reg_out.step_down_en && !reg_out.step_up_en)
        else $error("converter on in sleep or fail-safe");
    event_stop_a: assert property (
        reg_out.upshift_event |-> mode_state == MODE_STOP
        ##1 reg_out.step_down_pwm) else $error("bad upshift event");
    event_once_a: assert property (
        reg_out.upshift_event |=> !reg_out.upshift_event[*8])
        else $error("repeated upshift event");
    wake_pwm_a: assert property (
        (mode_state == MODE_STOP && hw[HW_WAKE_PIN_MOD] && wake_input)[*5]
        |-> reg_out.step_down_pwm) else $error("wake high not pwm");
    release_normal_a: assert property (
        $rose(reg_out.reset_output_n) |-> ##[0:3] mode_state == MODE_NORMAL)
        else $error("no normal mode after release");
    restart_hold_a: assert property (
        (mode_state == MODE_RESTART && !analog_in.step_down_above_rst)[*4]
        |-> !reg_out.reset_output_n) else $error("reset released early");
    boost_keep_a: assert property (
        $past(mode_state) == MODE_STOP && mode_state == MODE_NORMAL
        |-> $stable(reg_out.step_up_en)) else $error("boost changed");
    level_follow_a: assert property (
        $stable(hw) |-> step_up_level == hw[HW_STEP_UP_LEVEL])
        else $error("level select not followed");

    // Main scenarios
    cover property (reg_out.upshift_event);
    cover property (mode_state == MODE_RESTART ##1 mode_state == MODE_NORMAL);
    cover property (pready && pslverr);
endmodule : buck_boost_mode_control_sva

bind buck_boost_mode_control buck_boost_mode_control_sva i_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_input(wake_input),
    .analog_in(analog_in), .reg_out(reg_out), .mode_state(mode_state),
    .step_up_level(step_up_level));
`default_nettype wire

// file: buck_boost_mode_control_tb.sv
// Self-checking bench for the buck/boost modulation control block.
// Assumes the package, design, checker and host model compile first.
`timescale 1ns/100ps
`default_nettype none
module buck_boost_mode_control_tb;
    import smps_mode_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        want_pwm, wake_input, step_up_level, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    analog_in_t  ain;
    reg_out_t    ro;
    sbc_mode_t   mode;
    int          fails, cmp_count, ev;

    buck_boost_mode_control i_dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wake_input(wake_input), .analog_in(ain),
        .reg_out(ro), .mode_state(mode), .step_up_level(step_up_level));
    host_wake_model i_host (.pclk(pclk), .rst_n(presetn),
        .want_pwm(want_pwm), .wake_input(wake_input));

    always #20 pclk = ~pclk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // One transfer; waits for pready, extra idle cycle keeps drives apart
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 32'(pready), 1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic go(input logic [1:0] cmd);
        apb(1'b1, MODE_CTRL_ADDR, {30'h0, cmd});
    endtask : go

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_boot();
        chk("mode", 32'(mode), 32'(MODE_NORMAL));
        chk("release", 32'(ro.reset_output_n), 1);
        chk("pwm", 32'(ro.step_down_pwm), 1);
        apb(1'b0, HW_CONTROL_ADDR, 0);
        chk("hw reset", rd, 32'(HW_CONTROL_RESET));
        apb(1'b0, 8'h40, 0);
        chk("unmapped err", 32'(err), 1);
        chk("unmapped data", rd, 0);
    endtask : t_boot

    // Stop entry keeps pwm for the lag, then pfm; normal brings pwm back
    task automatic t_stop(input logic [31:0] hw, input int lag);
        apb(1'b1, HW_CONTROL_ADDR, hw);
        go(CMD_STOP);
        cyc(lag - 20);
        chk("pwm in lag", 32'(ro.step_down_pwm), 1);
        cyc(40);
        chk("pwm after lag", 32'(ro.step_down_pwm), 0);
        chk("mode stop", 32'(mode), 32'(MODE_STOP));
    endtask : t_stop

    task automatic back_normal();
        go(CMD_NORMAL);
        cyc(4);
        chk("pwm normal", 32'(ro.step_down_pwm), 1);
        chk("mode normal", 32'(mode), 32'(MODE_NORMAL));
    endtask : back_normal

    task automatic t_upshift(input logic [31:0] hw, input logic expect_up);
        t_stop(hw, LAG_SHORT_CYC);
        ain.step_down_high_load <= 1'b1;
        ev = 0;
        repeat (60) begin
            @(posedge pclk);
            if (ro.upshift_event === 1'b1) ev++;
        end
        chk("events", ev, 32'(expect_up));
        chk("pwm up", 32'(ro.step_down_pwm), 32'(expect_up));
        apb(1'b0, WAKE_STAT1_ADDR, 0);
        chk("flag", rd & 32'h1, 32'(expect_up));
        apb(1'b1, WAKE_STAT1_ADDR, 32'h1);
        apb(1'b0, WAKE_STAT1_ADDR, 0);
        chk("flag clear", rd & 32'h1, 0);
        ain.step_down_high_load <= 1'b0;
        if (expect_up) begin
            t_stop(hw, LAG_SHORT_CYC);
        end
        back_normal();
    endtask : t_upshift

    task automatic t_wake();
        t_stop(32'h14, LAG_SHORT_CYC);
        want_pwm <= 1'b1;
        cyc(6);
        chk("wake pwm", 32'(ro.step_down_pwm), 1);
        want_pwm <= 1'b0;
        cyc(LAG_SHORT_CYC + 20);
        chk("wake pfm", 32'(ro.step_down_pwm), 0);
        apb(1'b1, HW_CONTROL_ADDR, 32'h04);
        want_pwm <= 1'b1;
        cyc(10);
        chk("pin ignored", 32'(ro.step_down_pwm), 0);
        want_pwm <= 1'b0;
        back_normal();
    endtask : t_wake

    task automatic t_boost();
        apb(1'b1, HW_CONTROL_ADDR, 32'h07);
        ain.step_up_below_th <= 1'b1;
        ain.step_up_above_hys <= 1'b0;
        cyc(6);
        chk("level", 32'(step_up_level), 1);
        chk("boost on", 32'(ro.step_up_en), 1);
        apb(1'b1, WAKE_STAT1_ADDR, 32'h2);
        apb(1'b0, WAKE_STAT1_ADDR, 0);
        chk("active kept", rd & 32'h2, 32'h2);
        ain.step_up_overcurrent <= 1'b1;
        cyc(6);
        chk("duty cut", 32'(ro.duty_reduce), 1);
        ain.step_up_overcurrent <= 1'b0;
        go(CMD_STOP);
        cyc(6);
        chk("boost stop", 32'(ro.step_up_en), 1);
        back_normal();
        chk("boost kept", 32'(ro.step_up_en), 1);
        ain.step_up_below_th <= 1'b0;
        ain.step_up_above_hys <= 1'b1;
        cyc(6);
        chk("boost off", 32'(ro.step_up_en), 0);
        apb(1'b1, WAKE_STAT1_ADDR, 32'h2);
        apb(1'b0, WAKE_STAT1_ADDR, 0);
        chk("active clear", rd & 32'h2, 0);
    endtask : t_boost

    task automatic t_sleep(input logic fs);
        ain.step_up_below_th <= 1'b1;
        apb(1'b1, HW_CONTROL_ADDR, 32'h05);
        if (fs) ain.fail_safe_req <= 1'b1;
        else go(CMD_SLEEP);
        cyc(6);
        chk("mode off", 32'(mode),
            fs ? 32'(MODE_FAILSAFE) : 32'(MODE_SLEEP));
        chk("buck off", 32'(ro.step_down_en), 0);
        chk("boost off", 32'(ro.step_up_en), 0);
        ain.fail_safe_req <= 1'b0;
        ain.step_down_above_rst <= 1'b0;
        ain.wake_event <= 1'b1;
        cyc(6);
        chk("restart", 32'(mode), 32'(MODE_RESTART));
        chk("reset held", 32'(ro.reset_output_n), 0);
        chk("buck ramp", 32'(ro.step_down_en), 1);
        chk("boost back", 32'(ro.step_up_en), 1);
        ain.wake_event <= 1'b0;
        ain.step_down_above_rst <= 1'b1;
        cyc(8);
        chk("reset free", 32'(ro.reset_output_n), 1);
        chk("normal", 32'(mode), 32'(MODE_NORMAL));
        ain.step_up_below_th <= 1'b0;
    endtask : t_sleep

    // ----------------------------------------------------------------
    // Verdict, watchdog and main sequence
    // ----------------------------------------------------------------
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : wrap_up

    // Tests need about 41k cycles; cut a hang at 80k
    initial begin
        #(80000 * 40);
        fails++;
        wrap_up();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, want_pwm} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ain = '0;
        ain.step_down_above_rst = 1'b1;
        ain.step_up_above_hys = 1'b1;
        cyc(4);
        presetn <= 1'b1;
        cyc(10);
        t_boot();
        t_stop(32'h04, LAG_SHORT_CYC);
        back_normal();
        t_stop(32'h0c, LAG_LONG_CYC);
        back_normal();
        t_upshift(32'h04, 1'b1);
        t_upshift(32'h00, 1'b0);
        t_wake();
        t_boost();
        t_sleep(1'b0);
        t_sleep(1'b1);
        wrap_up();
    end
endmodule : buck_boost_mode_control_tb
`default_nettype wire

// file: host_wake_model.sv
// Host side of the wake pin: turns a modulation wish into a pin level.
// Assumes the host decides on pclk edges; the pin has no pull.
`timescale 1ns/100ps
`default_nettype none
module host_wake_model (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic rst_n,
    // Wish and pin
    input  wire logic want_pwm,
    output var logic  wake_input
);
    // Registered, so the pin never shows a glitch or an unknown
    always_ff @(posedge pclk or negedge rst_n) begin
        if (!rst_n) wake_input <= 1'b0;
        else wake_input <= want_pwm;
    end
endmodule : host_wake_model
`default_nettype wire

// file: smps_mode_pkg.sv
// Package for the buck/boost modulation control block.
// Assumes a single 25 MHz pclk and an APB slave with 32-bit data.
package smps_mode_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ       = 25;
    localparam int LAG_LONG_US   = 1000;   // 1 ms
    localparam int LAG_SHORT_US  = 100;    // 100 us
    localparam int LAG_LONG_CYC  = LAG_LONG_US * CLK_MHZ;
    localparam int LAG_SHORT_CYC = LAG_SHORT_US * CLK_MHZ;
    localparam int LAG_W         = 15;
    // Upshift current threshold, mA (analog comparator outside)
    localparam int UPSHIFT_TH_MIN_MA = 80;
    localparam int UPSHIFT_TH_TYP_MA = 110;
    localparam int UPSHIFT_TH_MAX_MA = 150;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_CTRL_ADDR   = 8'h00;
    localparam logic [7:0] HW_CONTROL_ADDR  = 8'h04;
    localparam logic [7:0] WAKE_STAT1_ADDR  = 8'h08;
    localparam logic [7:0] SMPS_STATE_ADDR  = 8'h0c;

    // Mode control field values (bits 1:0)
    localparam logic [1:0] CMD_NORMAL = 2'h0;
    localparam logic [1:0] CMD_STOP   = 2'h1;
    localparam logic [1:0] CMD_SLEEP  = 2'h2;

    // Hardware control bit positions
    localparam int HW_STEP_UP_EN    = 0;
    localparam int HW_STEP_UP_LEVEL = 1;
    localparam int HW_AUTO_UPSHIFT  = 2;
    localparam int HW_LAG_SELECT    = 3;
    localparam int HW_WAKE_PIN_MOD  = 4;
    localparam logic [4:0] HW_CONTROL_RESET = 5'h04;

    // First wake status bit positions
    localparam int WS_UPSHIFT     = 0;
    localparam int WS_STEP_UP_ACT = 1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_NORMAL   = 3'b000,
        MODE_STOP     = 3'b001,
        MODE_SLEEP    = 3'b010,
        MODE_FAILSAFE = 3'b011,
        MODE_RESTART  = 3'b100
    } sbc_mode_t;

    typedef struct packed {
        logic step_down_en;
        logic step_down_pwm;
        logic step_up_en;
        logic duty_reduce;
        logic reset_output_n;
        logic upshift_event;
    } reg_out_t;

    typedef struct packed {
        logic step_down_high_load;  // Load above upshift threshold
        logic step_down_above_rst;  // Output above reset threshold
        logic step_up_below_th;     // Sensed output below threshold
        logic step_up_above_hys;    // Sensed output above th + hys
        logic step_up_overcurrent;  // Shunt trip voltage exceeded
        logic wake_event;           // Wake pin or transceiver wake
        logic fail_safe_req;        // Fail-safe entry request
    } analog_in_t;

endpackage : smps_mode_pkg
